// File: hdl/wrt_pkg.sv
package wrt_pkg;

	////////////////////////////////////////////////////////////////////////
	// register offsets
	localparam logic [7:0] WRT_OFF_RESTART_ST = 8'h1E;
	localparam logic [7:0] WRT_OFF_SOFT_RESET = 8'h1F;
	localparam logic [7:0] WRT_OFF_TOP_EVENT  = 8'h20;
	localparam logic [7:0] WRT_OFF_TOP_EVENT2 = 8'h21;

	////////////////////////////////////////////////////////////////////////
	// field positions
	localparam int WRT_WD_CLR_FLAG_BIT = 4;
	localparam int WRT_WD_FLAG_BIT     = 3;
	localparam int WRT_WD_CLR_CNT_BIT  = 2;
	localparam int WRT_SRST_BIT        = 0;
	localparam int WRT_TOP_MEAS_BIT    = 7;
	localparam int WRT_TOP_DIAG_BIT    = 6;
	localparam int WRT_TOP_BOOST_BIT   = 5;
	localparam int WRT_TOP_BUCK_BIT    = 4;
	localparam int WRT_TOP_SYNC_BIT    = 3;
	localparam int WRT_TOP_TSD_BIT     = 2;
	localparam int WRT_TOP_TWARN_BIT   = 1;
	localparam int WRT_TOP_OVP_BIT     = 0;
	localparam int WRT_TOP2_RST_BIT    = 0;

	// index of each latched top-level event inside the latch vector
	localparam int WRT_LAT_OVP   = 0;
	localparam int WRT_LAT_TWARN = 1;
	localparam int WRT_LAT_TSD   = 2;
	localparam int WRT_LAT_SYNC  = 3;
	localparam int WRT_LAT_MEAS  = 4;
	localparam int WRT_LAT_N     = 5;

	////////////////////////////////////////////////////////////////////////
	// reset values and counter maximum
	localparam logic [7:0] WRT_RST_BYTE = 8'h00;
	localparam logic [4:0] WRT_RST_LAT  = 5'h00;
	localparam logic [1:0] WRT_RST_CNT  = 2'h0;
	localparam logic [1:0] WRT_CNT_MAX  = 2'h3;

	////////////////////////////////////////////////////////////////////////
	// restart threshold select codes and pulse counts
	localparam logic [1:0] WRT_SEL_OFF  = 2'h0;
	localparam logic [1:0] WRT_SEL_ONE  = 2'h1;
	localparam logic [1:0] WRT_SEL_TWO  = 2'h2;
	localparam logic [2:0] WRT_THR_OFF  = 3'h0;
	localparam logic [2:0] WRT_THR_ONE  = 3'h1;
	localparam logic [2:0] WRT_THR_TWO  = 3'h2;
	localparam logic [2:0] WRT_THR_FOUR = 3'h4;

	typedef enum logic [1:0] {
		WRT_SR_IDLE   = 2'b00,
		WRT_SR_APPLY  = 2'b01,
		WRT_SR_RELOAD = 2'b10
	} wrt_sr_state_t;

endpackage

// File: hdl/wrt_restart_ctr.sv
`timescale 1ns/100ps
module wrt_restart_ctr (
	input  logic       mclk,
	input  logic       resetn,
	input  logic       ce,
	input  logic       soft_clear,
	input  logic       watchdog_reset_output,
	input  logic       count_clear,
	input  logic       flag_clear,
	input  logic [1:0] restart_threshold_select,
	input  logic       restart_flag_blocking_mode,
	output logic [1:0] reset_pulse_count_value,
	output logic       watchdog_restart_occurred,
	output logic       system_restart_request
);

	logic [1:0] cnt_r;
	logic [1:0] cnt_nxt;
	logic       flag_r;
	logic       flag_nxt;
	logic       req_r;
	wire  [1:0] cnt_base;
	wire  [2:0] cnt_inc;
	wire  [2:0] thr;
	wire        blocked;
	wire        hit;

	////////////////////////////////////////////////////////////////////////
	// a clear in the same cycle as a pulse still counts that pulse
	assign cnt_base = count_clear ? wrt_pkg::WRT_RST_CNT : cnt_r;
	assign cnt_inc  = {1'b0, cnt_base} + 3'h1;
	assign thr = (restart_threshold_select == wrt_pkg::WRT_SEL_OFF) ? wrt_pkg::WRT_THR_OFF :
		(restart_threshold_select == wrt_pkg::WRT_SEL_ONE) ? wrt_pkg::WRT_THR_ONE :
		(restart_threshold_select == wrt_pkg::WRT_SEL_TWO) ? wrt_pkg::WRT_THR_TWO : wrt_pkg::WRT_THR_FOUR;
	assign blocked = restart_flag_blocking_mode & flag_r;
	// a threshold lowered below the count still restarts
	assign hit = watchdog_reset_output & (thr != wrt_pkg::WRT_THR_OFF) & (cnt_inc >= thr) & ~blocked;

	// count saturates when no restart can be taken
	assign cnt_nxt = soft_clear ? wrt_pkg::WRT_RST_CNT :
		hit ? wrt_pkg::WRT_RST_CNT :
		(watchdog_reset_output && cnt_base != wrt_pkg::WRT_CNT_MAX) ? cnt_inc[1:0] : cnt_base;
	// set wins over the clear pulse
	assign flag_nxt = soft_clear ? 1'b0 : hit ? 1'b1 : flag_clear ? 1'b0 : flag_r;

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			cnt_r  <= wrt_pkg::WRT_RST_CNT;
			flag_r <= 1'b0;
			req_r  <= 1'b0;
		end else if (ce) begin
			cnt_r  <= cnt_nxt;
			flag_r <= flag_nxt;
			req_r  <= hit & ~soft_clear;
		end
	end

	assign reset_pulse_count_value   = cnt_r;
	assign watchdog_restart_occurred = flag_r;
	assign system_restart_request    = req_r;

	////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!resetn);

	property p_flag_only_by_clear;
		$fell(flag_r) |-> $past(flag_clear || soft_clear);
	endproperty
	a_flag_only_by_clear: assert property (p_flag_only_by_clear) else $error("restart flag fell without clear");

	property p_count_clear;
		ce && count_clear && !watchdog_reset_output && !soft_clear |=> cnt_r == 2'h0;
	endproperty
	a_count_clear: assert property (p_count_clear) else $error("counter not cleared");

	property p_thr_one;
		ce && !soft_clear && watchdog_reset_output && restart_threshold_select == 2'h1 && !blocked
			|=> system_restart_request && watchdog_restart_occurred;
	endproperty
	a_thr_one: assert property (p_thr_one) else $error("threshold one did not restart");

	property p_thr_off;
		ce && restart_threshold_select == 2'h0 |=> !system_restart_request;
	endproperty
	a_thr_off: assert property (p_thr_off) else $error("restart while disabled");

	property p_blocking;
		ce && restart_flag_blocking_mode && flag_r |=> !system_restart_request;
	endproperty
	a_blocking: assert property (p_blocking) else $error("restart while flag blocks");

	c_restart: cover property (system_restart_request);

endmodule

// File: hdl/wrt_regs.sv
`timescale 1ns/100ps
module wrt_regs (
	input  logic       mclk,
	input  logic       resetn,
	input  logic       ce,
	input  logic [7:0] reg_addr,
	input  logic [7:0] reg_wdata,
	input  logic       reg_wr,
	input  logic       reg_rd,
	output logic [7:0] reg_rdata,
	input  logic       watchdog_reset_output,
	input  logic [1:0] restart_threshold_select,
	input  logic       restart_flag_blocking_mode,
	input  logic       meas_result_ready,
	input  logic [7:0] diagnostic_event_register,
	input  logic [7:0] boost_event_register,
	input  logic [7:0] buck_event_register,
	input  logic       sync_clk_valid,
	input  logic       thermal_shutdown_live,
	input  logic       thermal_warning_live,
	input  logic       input_overvoltage_live,
	input  logic       supply_undervoltage,
	output logic       system_restart_request,
	output logic       watchdog_restart_occurred,
	output logic       converter_enable_allowed,
	output logic       thermal_warning_clear,
	output logic       soft_reset_pulse,
	output logic       otp_reload_request
);

	////////////////////////////////////////////////////////////////////////
	// register access decode
	wire wr_wd   = ce & reg_wr & (reg_addr == wrt_pkg::WRT_OFF_RESTART_ST);
	wire wr_srst = ce & reg_wr & (reg_addr == wrt_pkg::WRT_OFF_SOFT_RESET);
	wire wr_top  = ce & reg_wr & (reg_addr == wrt_pkg::WRT_OFF_TOP_EVENT);
	wire wr_top2 = ce & reg_wr & (reg_addr == wrt_pkg::WRT_OFF_TOP_EVENT2);

	wrt_pkg::wrt_sr_state_t sr_state_r;
	wrt_pkg::wrt_sr_state_t sr_state_nxt;
	wire sr_apply = (sr_state_r == wrt_pkg::WRT_SR_APPLY);

	// status register honours no lock; clears land except in the soft reset apply cycle
	wire req_clr_flag = wr_wd & reg_wdata[wrt_pkg::WRT_WD_CLR_FLAG_BIT] & ~sr_apply;
	wire req_clr_cnt  = wr_wd & reg_wdata[wrt_pkg::WRT_WD_CLR_CNT_BIT] & ~sr_apply;
	wire req_srst     = wr_srst & reg_wdata[wrt_pkg::WRT_SRST_BIT];

	////////////////////////////////////////////////////////////////////////
	// clear pulses, visible in the register for their single cycle
	logic clr_flag_r;
	logic clr_cnt_r;

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			clr_flag_r <= 1'b0;
			clr_cnt_r  <= 1'b0;
		end else if (ce) begin
			clr_flag_r <= req_clr_flag;
			clr_cnt_r  <= req_clr_cnt;
		end
	end

	logic [1:0] cnt_val;
	logic       restart_flag;

	wrt_restart_ctr u_ctr (
		.mclk                       (mclk),
		.resetn                     (resetn),
		.ce                         (ce),
		.soft_clear                 (sr_apply),
		.watchdog_reset_output      (watchdog_reset_output),
		.count_clear                (clr_cnt_r),
		.flag_clear                 (clr_flag_r),
		.restart_threshold_select   (restart_threshold_select),
		.restart_flag_blocking_mode (restart_flag_blocking_mode),
		.reset_pulse_count_value    (cnt_val),
		.watchdog_restart_occurred  (restart_flag),
		.system_restart_request     (system_restart_request)
	);

	assign watchdog_restart_occurred = restart_flag;

	////////////////////////////////////////////////////////////////////////
	// soft reset sequence: apply defaults, then request reload, then idle
	always_comb begin
		case (sr_state_r)
			wrt_pkg::WRT_SR_IDLE: begin
				sr_state_nxt = req_srst ? wrt_pkg::WRT_SR_APPLY : wrt_pkg::WRT_SR_IDLE;
			end
			wrt_pkg::WRT_SR_APPLY: begin
				sr_state_nxt = wrt_pkg::WRT_SR_RELOAD;
			end
			wrt_pkg::WRT_SR_RELOAD: begin
				sr_state_nxt = wrt_pkg::WRT_SR_IDLE;
			end
			default: begin
				sr_state_nxt = wrt_pkg::WRT_SR_IDLE;
			end
		endcase
	end

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			sr_state_r <= wrt_pkg::WRT_SR_IDLE;
		end else if (ce) begin
			sr_state_r <= sr_state_nxt;
		end
	end

	assign soft_reset_pulse   = sr_apply;
	assign otp_reload_request = (sr_state_r == wrt_pkg::WRT_SR_RELOAD);
	wire   srst_bit           = (sr_state_r != wrt_pkg::WRT_SR_IDLE);

	////////////////////////////////////////////////////////////////////////
	// sync clock validity edge; the first cycle after reset only arms
	logic sync_prev_r;
	logic sync_armed_r;

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			sync_prev_r  <= 1'b0;
			sync_armed_r <= 1'b0;
		end else if (ce) begin
			sync_prev_r  <= sync_clk_valid;
			sync_armed_r <= 1'b1;
		end
	end

	wire sync_change = sync_armed_r & (sync_clk_valid ^ sync_prev_r);

	////////////////////////////////////////////////////////////////////////
	// latched top-level events; set wins over a write-one clear
	logic [wrt_pkg::WRT_LAT_N-1:0] lat_r;
	wire  [wrt_pkg::WRT_LAT_N-1:0] lat_set;
	wire  [wrt_pkg::WRT_LAT_N-1:0] lat_w1c;

	assign lat_set[wrt_pkg::WRT_LAT_MEAS]  = meas_result_ready;
	assign lat_set[wrt_pkg::WRT_LAT_SYNC]  = sync_change;
	assign lat_set[wrt_pkg::WRT_LAT_TSD]   = thermal_shutdown_live;
	assign lat_set[wrt_pkg::WRT_LAT_TWARN] = thermal_warning_live;
	assign lat_set[wrt_pkg::WRT_LAT_OVP]   = input_overvoltage_live;

	// only ones clear; zeros leave the bit alone
	assign lat_w1c = wr_top ? {reg_wdata[wrt_pkg::WRT_TOP_MEAS_BIT],
		reg_wdata[wrt_pkg::WRT_TOP_SYNC_BIT], reg_wdata[wrt_pkg::WRT_TOP_TSD_BIT],
		reg_wdata[wrt_pkg::WRT_TOP_TWARN_BIT], reg_wdata[wrt_pkg::WRT_TOP_OVP_BIT]} : wrt_pkg::WRT_RST_LAT;

	genvar gi;
	generate
		for (gi = 0; gi < wrt_pkg::WRT_LAT_N; gi++) begin : g_lat
			always_ff @(posedge mclk or negedge resetn) begin
				if (!resetn) begin
					lat_r[gi] <= 1'b0;
				end else if (ce) begin
					lat_r[gi] <= sr_apply ? 1'b0 : (lat_set[gi] | (lat_r[gi] & ~lat_w1c[gi]));
				end
			end
		end
	endgenerate

	// converters stay off while the shutdown bit is latched
	assign converter_enable_allowed = ~lat_r[wrt_pkg::WRT_LAT_TSD];

	// a real clear of the shutdown bit also clears the live warning status
	logic twc_r;
	wire  tsd_cleared = lat_w1c[wrt_pkg::WRT_LAT_TSD] & lat_r[wrt_pkg::WRT_LAT_TSD] & ~thermal_shutdown_live;

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			twc_r <= 1'b0;
		end else if (ce) begin
			twc_r <= tsd_cleared & ~sr_apply;
		end
	end

	assign thermal_warning_clear = twc_r;

	////////////////////////////////////////////////////////////////////////
	// reset-event bit of the second top register
	logic rst_evt_r;
	wire  rst_evt_w1c = wr_top2 & reg_wdata[wrt_pkg::WRT_TOP2_RST_BIT];

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			rst_evt_r <= 1'b0;
		end else if (ce) begin
			rst_evt_r <= sr_apply | supply_undervoltage | (rst_evt_r & ~rst_evt_w1c);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// readback; summaries are live, so they drop as soon as the source clears
	wire diag_pend  = |diagnostic_event_register;
	wire boost_pend = |boost_event_register;
	wire buck_pend  = |buck_event_register;

	wire [7:0] rd_wd   = {3'h0, clr_flag_r, restart_flag, clr_cnt_r, cnt_val};
	wire [7:0] rd_srst = {7'h00, srst_bit};
	wire [7:0] rd_top  = {lat_r[wrt_pkg::WRT_LAT_MEAS], diag_pend, boost_pend, buck_pend,
		lat_r[wrt_pkg::WRT_LAT_SYNC], lat_r[wrt_pkg::WRT_LAT_TSD],
		lat_r[wrt_pkg::WRT_LAT_TWARN], lat_r[wrt_pkg::WRT_LAT_OVP]};
	wire [7:0] rd_top2 = {7'h00, rst_evt_r};

	wire [7:0] rd_mux = (reg_addr == wrt_pkg::WRT_OFF_RESTART_ST) ? rd_wd :
		(reg_addr == wrt_pkg::WRT_OFF_SOFT_RESET) ? rd_srst :
		(reg_addr == wrt_pkg::WRT_OFF_TOP_EVENT)  ? rd_top :
		(reg_addr == wrt_pkg::WRT_OFF_TOP_EVENT2) ? rd_top2 : wrt_pkg::WRT_RST_BYTE;

	logic [7:0] rdata_r;

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			rdata_r <= wrt_pkg::WRT_RST_BYTE;
		end else if (ce && reg_rd) begin
			rdata_r <= rd_mux;
		end
	end

	assign reg_rdata = rdata_r;

	////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!resetn);

	property p_clr_flag_pulse;
		wr_wd && reg_wdata[4] && !sr_apply |=> clr_flag_r ##1 (!ce || !clr_flag_r || $past(req_clr_flag));
	endproperty
	a_clr_flag_pulse: assert property (p_clr_flag_pulse) else $error("flag clear pulse wrong");

	property p_soft_reset;
		ce && sr_apply |=> lat_r == 5'h00 && rst_evt_r && !clr_flag_r && otp_reload_request;
	endproperty
	a_soft_reset: assert property (p_soft_reset) else $error("soft reset did not restore");

	property p_srst_selfclear;
		ce && req_srst && sr_state_r == wrt_pkg::WRT_SR_IDLE |=> srst_bit && sr_apply
			##1 (!ce || otp_reload_request) ##1 (!ce || !sr_apply);
	endproperty
	a_srst_selfclear: assert property (p_srst_selfclear) else $error("soft reset bit stuck");

	property p_meas_latch;
		ce && meas_result_ready && !sr_apply |=> lat_r[4];
	endproperty
	a_meas_latch: assert property (p_meas_latch) else $error("measurement event lost");

	property p_diag_summary;
		ce && reg_rd && reg_addr == 8'h20 |=> reg_rdata[6] == $past(diag_pend) && reg_rdata[5] == $past(boost_pend);
	endproperty
	a_diag_summary: assert property (p_diag_summary) else $error("summary bit wrong");

	property p_sync_edge;
		ce && sync_armed_r && sync_clk_valid != sync_prev_r && !sr_apply |=> lat_r[3];
	endproperty
	a_sync_edge: assert property (p_sync_edge) else $error("sync change not latched");

	property p_tsd_block;
		ce && thermal_shutdown_live && !sr_apply |=> !converter_enable_allowed;
	endproperty
	a_tsd_block: assert property (p_tsd_block) else $error("converters allowed in shutdown");

	property p_tsd_clear;
		ce && tsd_cleared && !sr_apply |=> converter_enable_allowed && thermal_warning_clear;
	endproperty
	a_tsd_clear: assert property (p_tsd_clear) else $error("shutdown clear failed");

	property p_zero_write;
		ce && wr_top && reg_wdata == 8'h00 && !sr_apply |=> ($past(lat_r) & ~lat_r) == 5'h00;
	endproperty
	a_zero_write: assert property (p_zero_write) else $error("zero write cleared a bit");

	property p_buck_summary;
		ce && reg_rd && reg_addr == 8'h20 |=> reg_rdata[4] == $past(|buck_event_register);
	endproperty
	a_buck_summary: assert property (p_buck_summary) else $error("buck summary bit wrong");

	property p_twarn_latch;
		ce && thermal_warning_live && !sr_apply |=> lat_r[1];
	endproperty
	a_twarn_latch: assert property (p_twarn_latch) else $error("thermal warning event lost");

	property p_ovp_latch;
		ce && input_overvoltage_live && !sr_apply |=> lat_r[0];
	endproperty
	a_ovp_latch: assert property (p_ovp_latch) else $error("overvoltage event lost");

	property p_uv_event;
		ce && supply_undervoltage |=> rst_evt_r;
	endproperty
	a_uv_event: assert property (p_uv_event) else $error("reset event not latched");

	c_soft_reset: cover property (ce && req_srst ##1 sr_apply);
	c_tsd_clear: cover property (tsd_cleared);
	c_flag_clear: cover property (restart_flag ##1 clr_flag_r);

endmodule

// File: verif/wrt_host.sv
`timescale 1ns/100ps
module wrt_host (
	input  wire logic       mclk,
	output logic [7:0] reg_addr,
	output logic [7:0] reg_wdata,
	output logic       reg_wr,
	output logic       reg_rd,
	input  wire logic [7:0] reg_rdata
);
	initial begin
		reg_addr  = 8'h00;
		reg_wdata = 8'h00;
		reg_wr    = 1'b0;
		reg_rd    = 1'b0;
	end

	////////////////////////////////////////////////////////////////////////
	// released lines show the inverse so stale values never pass
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge mclk);
		reg_addr  = a;
		reg_wdata = d;
		reg_wr    = 1'b1;
		@(negedge mclk);
		reg_wr    = 1'b0;
		reg_addr  = ~a;
		reg_wdata = ~d;
		// idle gap lets clear pulses and soft reset finish
		repeat (3) @(negedge mclk);
	endtask

	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(negedge mclk);
		reg_addr = a;
		reg_rd   = 1'b1;
		@(negedge mclk);
		d        = reg_rdata;
		reg_rd   = 1'b0;
		reg_addr = ~a;
	endtask
endmodule

// File: verif/wrt_regs_tb_top.sv
`timescale 1ns/100ps
module wrt_regs_tb_top;
	logic       mclk = 1'b0;
	logic       resetn = 1'b0;
	logic [7:0] reg_addr, reg_wdata, reg_rdata;
	logic       reg_wr, reg_rd;
	logic       wdo = 1'b0, mode = 1'b0, meas = 1'b0, sync = 1'b0, ce = 1'b1;
	logic [1:0] sel = 2'h0;
	logic [7:0] diag = 8'h00, boost = 8'h00, buck = 8'h00;
	logic       tsd = 1'b0, twarn = 1'b0, ovp = 1'b0, uv = 1'b0;
	logic       rr, flag, allowed, twc, srp, otp;
	logic [7:0] n_rr = 8'h00, n_twc = 8'h00, n_srp = 8'h00, n_otp = 8'h00;
	logic [7:0] thr [4] = '{8'h00, 8'h01, 8'h02, 8'h04};
	int         n_errors = 0;
	int         samples_checked = 0;
	int         cycles = 0;

	always #20 mclk = ~mclk;

	wrt_host i_wrt_host (.mclk(mclk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));

	wrt_regs i_wrt_regs (.mclk(mclk), .resetn(resetn), .ce(ce), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.watchdog_reset_output(wdo), .restart_threshold_select(sel),
		.restart_flag_blocking_mode(mode), .meas_result_ready(meas),
		.diagnostic_event_register(diag), .boost_event_register(boost),
		.buck_event_register(buck), .sync_clk_valid(sync), .thermal_shutdown_live(tsd),
		.thermal_warning_live(twarn), .input_overvoltage_live(ovp),
		.supply_undervoltage(uv), .system_restart_request(rr),
		.watchdog_restart_occurred(flag), .converter_enable_allowed(allowed),
		.thermal_warning_clear(twc), .soft_reset_pulse(srp), .otp_reload_request(otp));

	// one-cycle pulses are tallied so tasks need not hit their exact edge
	always @(posedge mclk) begin
		n_rr  <= n_rr + {7'h00, rr};
		n_twc <= n_twc + {7'h00, twc};
		n_srp <= n_srp + {7'h00, srp};
		n_otp <= n_otp + {7'h00, otp};
		cycles <= cycles + 1;
		if (cycles == 6000) begin
			n_errors++;
			results();
		end
	end

	////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_errors++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
		logic [7:0] d;
		i_wrt_host.rd(a, d);
		chk(d, exp);
	endtask

	task automatic pw(input int n);
		repeat (n) begin
			@(negedge mclk) wdo = 1'b1;
			@(negedge mclk) wdo = 1'b0;
		end
	endtask

	task automatic results();
		$display("comparisons %0d, mismatches %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////
	task automatic t_reset();
		chk({7'h00, allowed}, 8'h01);
		rdc(8'h1E, 8'h00);
		rdc(8'h1F, 8'h00);
		rdc(8'h20, 8'h00);
		rdc(8'h30, 8'h00);
	endtask

	task automatic t_count();
		pw(4);
		rdc(8'h1E, 8'h03);
		i_wrt_host.wr(8'h1E, 8'h00);
		rdc(8'h1E, 8'h03);
		i_wrt_host.wr(8'h1E, 8'h04);
		rdc(8'h1E, 8'h00);
		chk(n_rr, 8'h00);
	endtask

	// pulses while the enable is low must not count
	task automatic t_hold();
		@(negedge mclk) ce = 1'b0;
		pw(2);
		@(negedge mclk) ce = 1'b1;
		rdc(8'h1E, 8'h00);
	endtask

	task automatic t_restart();
		sel = 2'h1;
		pw(1);
		rdc(8'h1E, 8'h08);
		chk(n_rr, 8'h01);
		chk({7'h00, flag}, 8'h01);
		i_wrt_host.wr(8'h1E, 8'h08);
		rdc(8'h1E, 8'h08);
		mode = 1'b1;
		pw(1);
		rdc(8'h1E, 8'h09);
		chk(n_rr, 8'h01);
		i_wrt_host.wr(8'h1E, 8'h04);
		rdc(8'h1E, 8'h08);
		i_wrt_host.wr(8'h1E, 8'h10);
		rdc(8'h1E, 8'h00);
		mode = 1'b0;
		for (int i = 1; i < 4; i++) begin
			sel = i[1:0];
			pw(int'(thr[i]) - 1);
			rdc(8'h1E, thr[i] - 8'h01);
			pw(1);
			rdc(8'h1E, 8'h08);
			i_wrt_host.wr(8'h1E, 8'h10);
		end
		chk(n_rr, 8'h04);
		sel = 2'h0;
	endtask

	task automatic t_top();
		@(negedge mclk);
		meas = 1'b1;
		twarn = 1'b1;
		ovp = 1'b1;
		@(negedge mclk) meas = 1'b0;
		@(negedge mclk);
		twarn = 1'b0;
		ovp = 1'b0;
		rdc(8'h20, 8'h83);
		i_wrt_host.wr(8'h20, 8'h00);
		rdc(8'h20, 8'h83);
		i_wrt_host.wr(8'h20, 8'h80);
		rdc(8'h20, 8'h03);
		i_wrt_host.wr(8'h20, 8'h02);
		rdc(8'h20, 8'h01);
		i_wrt_host.wr(8'h20, 8'h01);
		rdc(8'h20, 8'h00);
		diag = 8'h01;
		rdc(8'h20, 8'h40);
		boost = 8'h04;
		rdc(8'h20, 8'h60);
		buck = 8'h40;
		i_wrt_host.wr(8'h20, 8'h70);
		rdc(8'h20, 8'h70);
		diag = 8'h00;
		boost = 8'h00;
		buck = 8'h00;
		rdc(8'h20, 8'h00);
	endtask

	task automatic t_sync();
		sync = 1'b1;
		rdc(8'h20, 8'h08);
		i_wrt_host.wr(8'h20, 8'h08);
		rdc(8'h20, 8'h00);
		sync = 1'b0;
		rdc(8'h20, 8'h08);
		i_wrt_host.wr(8'h20, 8'h08);
	endtask

	task automatic t_thermal();
		tsd = 1'b1;
		rdc(8'h20, 8'h04);
		chk({7'h00, allowed}, 8'h00);
		i_wrt_host.wr(8'h20, 8'h04);
		rdc(8'h20, 8'h04);
		chk(n_twc, 8'h00);
		tsd = 1'b0;
		i_wrt_host.wr(8'h20, 8'h04);
		rdc(8'h20, 8'h00);
		chk({7'h00, allowed}, 8'h01);
		chk(n_twc, 8'h01);
	endtask

	task automatic t_soft();
		@(negedge mclk) ovp = 1'b1;
		@(negedge mclk) ovp = 1'b0;
		pw(2);
		i_wrt_host.wr(8'h1F, 8'h01);
		chk(n_srp, 8'h01);
		chk(n_otp, 8'h01);
		rdc(8'h1F, 8'h00);
		rdc(8'h20, 8'h00);
		rdc(8'h1E, 8'h00);
		rdc(8'h21, 8'h01);
		i_wrt_host.wr(8'h21, 8'h01);
		rdc(8'h21, 8'h00);
		@(negedge mclk) uv = 1'b1;
		@(negedge mclk) uv = 1'b0;
		rdc(8'h21, 8'h01);
	endtask

	initial begin
		repeat (10) @(negedge mclk);
		resetn = 1'b1;
		t_reset();
		t_count();
		t_hold();
		t_restart();
		t_top();
		t_sync();
		t_thermal();
		t_soft();
		results();
	end
endmodule
